// ==== logic/fms_pkg.sv ====
/*
 * Shared constants and types of the four-mode serial port.
 * Assumes a single oscillator clock; the mode 0 clock shape and prescaler counts below are in its periods.
 */
`default_nettype none

package fms_pkg;

	// ********************************************
	// Mode encoding: {mode_select_high, mode_select_low}
	// ********************************************
	localparam logic [1:0] MODE_SYNC   = 2'h0;
	localparam logic [1:0] MODE_ASYNC8 = 2'h1;
	localparam logic [1:0] MODE_OSC9   = 2'h2;
	localparam logic [1:0] MODE_TMR9   = 2'h3;

	// ********************************************
	// Mode 0 shift clock shape, in oscillator clocks
	// ********************************************
	localparam logic [3:0] M0_PERIOD_SLOW = 4'hc;
	localparam logic [3:0] M0_LOW_SLOW    = 4'h6;
	localparam logic [3:0] M0_LEAD_SLOW   = 4'h3;
	localparam logic [3:0] M0_PERIOD_FAST = 4'h4;
	localparam logic [3:0] M0_LOW_FAST    = 4'h2;
	localparam logic [3:0] M0_LEAD_FAST   = 4'h1;
	localparam logic [3:0] M0_BITS        = 4'h8;

	// ********************************************
	// Oversampling and frame layout of the async modes
	// ********************************************
	localparam logic [3:0] OVS_LAST     = 4'hf;
	localparam logic [3:0] VOTE_FIRST   = 4'h7;
	localparam logic [3:0] VOTE_LAST    = 4'h9;
	localparam logic [3:0] NINTH_IDX    = 4'h9;
	localparam logic [3:0] LAST_IDX_10  = 4'h9;
	localparam logic [3:0] LAST_IDX_11  = 4'ha;
	localparam logic [1:0] OSC_TICK_FAST = 2'h1;
	localparam logic [1:0] OSC_TICK_SLOW = 2'h3;

	// ********************************************
	// Reset values
	// ********************************************
	localparam logic [7:0]  BUF_RESET  = 8'h00;
	localparam logic [10:0] IDLE_FRAME = 11'h7ff;

	// Software control bits, grouped
	typedef struct packed {
		logic mode_select_high;
		logic mode_select_low;
		logic mode_qualifier_bit;
		logic rx_enable;
		logic baud_double_bit;
		logic tx_ninth_bit;
	} fms_cfg_s;

	typedef enum logic [1:0] {
		TX_IDLE  = 2'b00,
		TX_ASYNC = 2'b01,
		TX_SYNC  = 2'b10
	} fms_tx_state_e;

	typedef enum logic [1:0] {
		RX_HUNT  = 2'b00,
		RX_FRAME = 2'b01,
		RX_SYNC  = 2'b10
	} fms_rx_state_e;

endpackage

`default_nettype wire

// ==== logic/fms_baud_tick.sv ====
/*
 * Sixteen-times oversampling tick for the asynchronous modes.
 * Assumes timer_ovf_i is a one-clock pulse from logic on the same clock.
 */
`timescale 1ns/1ps
`default_nettype none

module fms_baud_tick (
	input  wire logic       ref_clk_i,      // Oscillator clock
	input  wire logic       reset_i,        // Async reset, high
	input  wire logic [1:0] mode_i,         // Decoded mode
	input  wire logic       baud_double_i,  // Rate doubling
	input  wire logic       timer_ovf_i,    // Timer overflow pulse
	output logic            tick_o          // One-clock 16x tick
);

	logic [1:0] pre_q;
	logic [1:0] pre_d;
	logic       half_q;
	logic       half_d;
	logic       tick_q;
	logic       tick_d;
	logic [1:0] lim;

	// ****************************************
	// Prescaler: oscillator or timer driven
	// ****************************************
	always_comb
	begin
		lim    = baud_double_i ? fms_pkg::OSC_TICK_FAST : fms_pkg::OSC_TICK_SLOW;
		pre_d  = pre_q;
		half_d = half_q;
		tick_d = 1'b0;
		if (mode_i == fms_pkg::MODE_OSC9)
		begin
			// Bit of 32 or 64 clocks, so a tick each 2 or 4 clocks
			pre_d  = (pre_q >= lim) ? 2'h0 : pre_q + 2'h1;
			tick_d = (pre_q >= lim);
		end
		else if (mode_i != fms_pkg::MODE_SYNC)
		begin
			// Halving the overflow gives the 1/32 bit rate
			if (timer_ovf_i)
			begin
				half_d = ~half_q;
				tick_d = baud_double_i | half_q;
			end
		end
	end

	always_ff @(posedge ref_clk_i or posedge reset_i)
	begin
		if (reset_i)
		begin
			pre_q  <= 2'h0;
			half_q <= 1'b0;
			tick_q <= 1'b0;
		end
		else
		begin
			pre_q  <= pre_d;
			half_q <= half_d;
			tick_q <= tick_d;
		end
	end

	assign tick_o = tick_q;

endmodule // fms_baud_tick

`default_nettype wire

// ==== logic/fms_rx_sampler.sv ====
/*
 * Pin synchroniser and two-of-three voter for the data pin.
 * Assumes the pin is asynchronous to the oscillator clock.
 */
`timescale 1ns/1ps
`default_nettype none

module fms_rx_sampler (
	input  wire logic ref_clk_i,    // Oscillator clock
	input  wire logic reset_i,      // Async reset, high
	input  wire logic pin_i,        // Raw data pin
	input  wire logic sample_en_i,  // Keep current sample
	output logic      sync_o,       // Synchronised pin
	output logic      vote_o        // Majority of two kept and current
);

	logic       meta_q;
	logic       sync_q;
	logic [1:0] keep_q;
	logic [1:0] keep_d;

	// Keep the two earlier samples of the three
	always_comb
	begin
		keep_d = sample_en_i ? {keep_q[0], sync_q} : keep_q;
	end

	// Meta stage feeds only the second flop
	always_ff @(posedge ref_clk_i or posedge reset_i)
	begin
		if (reset_i)
		begin
			meta_q <= 1'b1;
			sync_q <= 1'b1;
			keep_q <= 2'h3;
		end
		else
		begin
			meta_q <= pin_i;
			sync_q <= meta_q;
			keep_q <= keep_d;
		end
	end

	assign sync_o = sync_q;
	assign vote_o = (keep_q[1] & keep_q[0]) | (keep_q[1] & sync_q) | (keep_q[0] & sync_q);

endmodule // fms_rx_sampler

`default_nettype wire

// ==== logic/fms_serial_port.sv ====
/*
 * Four-mode serial port: synchronous shifter (mode 0) and three async modes.
 * Assumes software-side strobes are one-clock pulses on ref_clk_i and the
 * data pin is asynchronous; the tx pin carries the mode 0 shift clock.
 */
`timescale 1ns/1ps
`default_nettype none

module fms_serial_port (
	input  wire logic             ref_clk_i,         // Oscillator clock, 10 MHz
	input  wire logic             reset_i,           // Async reset, high
	input  wire fms_pkg::fms_cfg_s cfg_i,            // Software control bits
	input  wire logic             timer_ovf_i,       // Timer overflow pulse
	input  wire logic             buf_wr_i,          // Serial buffer write strobe
	input  wire logic [7:0]       buf_wdata_i,       // Byte to transmit
	input  wire logic             tx_done_clr_i,     // Clear tx done flag
	input  wire logic             rx_done_clr_i,     // Clear rx done flag
	input  wire logic             data_pin_i,        // Data pin level
	output logic                  data_pin_o,        // Data pin drive value
	output logic                  data_pin_oe_n_o,   // Low while driving
	output logic                  txd_o,             // Tx line or shift clock
	output logic [7:0]            serial_buffer_o,   // Received byte
	output logic                  rx_ninth_bit_o,    // Received ninth bit
	output logic                  tx_done_flag_o,    // Transmit done
	output logic                  rx_done_flag_o     // Receive done
);

	logic [1:0]              mode;
	logic                    m0;
	logic [3:0]              per;
	logic [3:0]              fall_ph;
	logic [3:0]              lead_ph;
	logic                    tick;
	logic                    roll;
	logic                    rx_sync;
	logic                    vote;
	logic                    sample_en;
	logic                    realign;
	logic [3:0]              cnt_q;
	logic [3:0]              cnt_d;
	logic [3:0]              ph_q;
	logic [3:0]              ph_d;
	fms_pkg::fms_tx_state_e  tx_st_q;
	fms_pkg::fms_tx_state_e  tx_st_d;
	logic [10:0]             tx_frm_q;
	logic [10:0]             tx_frm_d;
	logic [3:0]              tx_cnt_q;
	logic [3:0]              tx_cnt_d;
	logic                    txd_q;
	logic                    txd_d;
	logic                    dout_q;
	logic                    dout_d;
	logic                    doe_n_q;
	logic                    doe_n_d;
	logic                    tx_done_q;
	logic                    tx_done_d;
	logic                    m0_act_d;
	fms_pkg::fms_rx_state_e  rx_st_q;
	fms_pkg::fms_rx_state_e  rx_st_d;
	logic [3:0]              rx_bit_q;
	logic [3:0]              rx_bit_d;
	logic [7:0]              rx_sh_q;
	logic [7:0]              rx_sh_d;
	logic                    rx_nin_q;
	logic                    rx_nin_d;
	logic                    rx_prev_q;
	logic                    rx_prev_d;
	logic [7:0]              buf_q;
	logic [7:0]              buf_d;
	logic                    rb8_q;
	logic                    rb8_d;
	logic                    rx_done_q;
	logic                    rx_done_d;
	logic [3:0]              last_idx;
	logic                    rb_val;

	// ****************************************
	// Mode decode and mode 0 clock shape
	// ****************************************
	assign mode     = {cfg_i.mode_select_high, cfg_i.mode_select_low};
	assign m0       = (mode == fms_pkg::MODE_SYNC);
	assign per      = cfg_i.mode_qualifier_bit ? fms_pkg::M0_PERIOD_FAST
	                                           : fms_pkg::M0_PERIOD_SLOW;
	assign fall_ph  = cfg_i.mode_qualifier_bit ? per - fms_pkg::M0_LOW_FAST
	                                           : per - fms_pkg::M0_LOW_SLOW;
	assign lead_ph  = cfg_i.mode_qualifier_bit ? fall_ph - fms_pkg::M0_LEAD_FAST
	                                           : fall_ph - fms_pkg::M0_LEAD_SLOW;
	assign last_idx = (mode == fms_pkg::MODE_ASYNC8) ? fms_pkg::LAST_IDX_10
	                                                 : fms_pkg::LAST_IDX_11;
	assign roll     = tick & (cnt_q == fms_pkg::OVS_LAST);

	// ****************************************
	// Rate source and pin sampler
	// ****************************************
	fms_baud_tick u_tick (
		.ref_clk_i     (ref_clk_i),
		.reset_i       (reset_i),
		.mode_i        (mode),
		.baud_double_i (cfg_i.baud_double_bit),
		.timer_ovf_i   (timer_ovf_i),
		.tick_o        (tick)
	);

	fms_rx_sampler u_samp (
		.ref_clk_i   (ref_clk_i),
		.reset_i     (reset_i),
		.pin_i       (data_pin_i),
		.sample_en_i (sample_en),
		.sync_o      (rx_sync),
		.vote_o      (vote)
	);

	// ****************************************
	// Timing: divide-by-16 counter and mode 0 phase
	// ****************************************
	// One counter serves both directions, so a realign also moves tx timing
	always_comb
	begin
		cnt_d = tick ? cnt_q + 4'h1 : cnt_q;
		if (realign)
		begin
			cnt_d = 4'h0;
		end
		if ((tx_st_q == fms_pkg::TX_SYNC) || (rx_st_q == fms_pkg::RX_SYNC))
		begin
			ph_d = (ph_q >= per - 4'h1) ? 4'h0 : ph_q + 4'h1;
		end
		else
		begin
			ph_d = 4'h0;
		end
	end

	always_ff @(posedge ref_clk_i or posedge reset_i)
	begin
		if (reset_i)
		begin
			cnt_q <= 4'h0;
			ph_q  <= 4'h0;
		end
		else
		begin
			cnt_q <= cnt_d;
			ph_q  <= ph_d;
		end
	end

	// ****************************************
	// Transmitter
	// ****************************************
	always_comb
	begin
		tx_st_d   = tx_st_q;
		tx_frm_d  = tx_frm_q;
		tx_cnt_d  = tx_cnt_q;
		txd_d     = txd_q;
		dout_d    = dout_q;
		doe_n_d   = doe_n_q;
		tx_done_d = tx_done_q & ~tx_done_clr_i;
		case (tx_st_q)
			fms_pkg::TX_IDLE:
			begin
				txd_d = 1'b1;
			end
			fms_pkg::TX_SYNC:
			begin
				if (ph_d == lead_ph)
				begin
					dout_d   = tx_frm_q[0];
					tx_frm_d = {1'b1, tx_frm_q[10:1]};
				end
				if (ph_q == per - 4'h1)
				begin
					tx_cnt_d = tx_cnt_q + 4'h1;
					if (tx_cnt_q == fms_pkg::M0_BITS - 4'h1)
					begin
						tx_st_d   = fms_pkg::TX_IDLE;
						doe_n_d   = 1'b1;
						tx_done_d = 1'b1;
					end
				end
			end
			fms_pkg::TX_ASYNC:
			begin
				if (roll)
				begin
					txd_d    = tx_frm_q[0];
					tx_frm_d = {1'b1, tx_frm_q[10:1]};
					tx_cnt_d = tx_cnt_q + 4'h1;
					if (tx_cnt_q == last_idx)
					begin
						tx_st_d   = fms_pkg::TX_IDLE;
						tx_done_d = 1'b1;
					end
				end
			end
			default:
			begin
				tx_st_d = fms_pkg::TX_IDLE;
			end
		endcase
		// A write restarts the transmitter whatever it was doing
		if (buf_wr_i)
		begin
			tx_cnt_d = 4'h0;
			if (m0)
			begin
				tx_frm_d = {3'h7, buf_wdata_i};
				tx_st_d  = fms_pkg::TX_SYNC;
				doe_n_d  = 1'b0;
			end
			else
			begin
				tx_frm_d = {1'b1, (mode == fms_pkg::MODE_ASYNC8) | cfg_i.tx_ninth_bit,
				            buf_wdata_i, 1'b0};
				tx_st_d  = fms_pkg::TX_ASYNC;
				doe_n_d  = 1'b1;
			end
		end
		// In mode 0 the tx pin is the shift clock, low in the back part of each period
		m0_act_d = (tx_st_d == fms_pkg::TX_SYNC) || (rx_st_d == fms_pkg::RX_SYNC);
		if (m0)
		begin
			txd_d = ~(m0_act_d & (ph_d >= fall_ph));
		end
	end

	always_ff @(posedge ref_clk_i or posedge reset_i)
	begin
		if (reset_i)
		begin
			tx_st_q   <= fms_pkg::TX_IDLE;
			tx_frm_q  <= fms_pkg::IDLE_FRAME;
			tx_cnt_q  <= 4'h0;
			txd_q     <= 1'b1;
			dout_q    <= 1'b1;
			doe_n_q   <= 1'b1;
			tx_done_q <= 1'b0;
		end
		else
		begin
			tx_st_q   <= tx_st_d;
			tx_frm_q  <= tx_frm_d;
			tx_cnt_q  <= tx_cnt_d;
			txd_q     <= txd_d;
			dout_q    <= dout_d;
			doe_n_q   <= doe_n_d;
			tx_done_q <= tx_done_d;
		end
	end

	// ****************************************
	// Receiver
	// ****************************************
	assign sample_en = tick & (rx_st_q == fms_pkg::RX_FRAME) &
	                   (cnt_q >= fms_pkg::VOTE_FIRST) & (cnt_q <= fms_pkg::VOTE_LAST);

	always_comb
	begin
		rx_st_d   = rx_st_q;
		rx_bit_d  = rx_bit_q;
		rx_sh_d   = rx_sh_q;
		rx_nin_d  = rx_nin_q;
		buf_d     = buf_q;
		rb8_d     = rb8_q;
		realign   = 1'b0;
		rb_val    = 1'b0;
		rx_prev_d = tick ? rx_sync : rx_prev_q;
		rx_done_d = rx_done_q & ~rx_done_clr_i;
		case (rx_st_q)
			fms_pkg::RX_HUNT:
			begin
				rx_bit_d = 4'h0;
				if (m0)
				begin
					// Starts only while the flag is clear and the line is free
					if (cfg_i.rx_enable && !rx_done_q && !buf_wr_i &&
					    (tx_st_q == fms_pkg::TX_IDLE))
					begin
						rx_st_d = fms_pkg::RX_SYNC;
					end
				end
				else if (cfg_i.rx_enable && tick && rx_prev_q && !rx_sync)
				begin
					realign = 1'b1;
					rx_st_d = fms_pkg::RX_FRAME;
				end
			end
			fms_pkg::RX_FRAME:
			begin
				if (tick && (cnt_q == fms_pkg::VOTE_LAST))
				begin
					rx_bit_d = rx_bit_q + 4'h1;
					if (rx_bit_q == 4'h0)
					begin
						if (vote)
						begin
							rx_st_d = fms_pkg::RX_HUNT;
						end
					end
					else if (rx_bit_q == last_idx)
					begin
						// Middle of the stop bit: decide, then hunt again
						rb_val  = (mode == fms_pkg::MODE_ASYNC8) ? vote : rx_nin_q;
						rx_st_d = fms_pkg::RX_HUNT;
						if (!rx_done_q && (!cfg_i.mode_qualifier_bit || rb_val))
						begin
							buf_d     = rx_sh_q;
							rb8_d     = rb_val;
							rx_done_d = 1'b1;
						end
					end
					else if (rx_bit_q == fms_pkg::NINTH_IDX)
					begin
						rx_nin_d = vote;
					end
					else
					begin
						rx_sh_d = {vote, rx_sh_q[7:1]};
					end
				end
			end
			fms_pkg::RX_SYNC:
			begin
				// Sample just as the shift clock rises; partner moved data at the fall
				if (ph_q == per - 4'h1)
				begin
					rx_sh_d  = {rx_sync, rx_sh_q[7:1]};
					rx_bit_d = rx_bit_q + 4'h1;
					if (rx_bit_q == fms_pkg::M0_BITS - 4'h1)
					begin
						buf_d     = {rx_sync, rx_sh_q[7:1]};
						rx_done_d = 1'b1;
						rx_st_d   = fms_pkg::RX_HUNT;
					end
				end
				if (buf_wr_i)
				begin
					rx_st_d = fms_pkg::RX_HUNT;
				end
			end
			default:
			begin
				rx_st_d = fms_pkg::RX_HUNT;
			end
		endcase
	end

	always_ff @(posedge ref_clk_i or posedge reset_i)
	begin
		if (reset_i)
		begin
			rx_st_q   <= fms_pkg::RX_HUNT;
			rx_bit_q  <= 4'h0;
			rx_sh_q   <= fms_pkg::BUF_RESET;
			rx_nin_q  <= 1'b0;
			rx_prev_q <= 1'b1;
			buf_q     <= fms_pkg::BUF_RESET;
			rb8_q     <= 1'b0;
			rx_done_q <= 1'b0;
		end
		else
		begin
			rx_st_q   <= rx_st_d;
			rx_bit_q  <= rx_bit_d;
			rx_sh_q   <= rx_sh_d;
			rx_nin_q  <= rx_nin_d;
			rx_prev_q <= rx_prev_d;
			buf_q     <= buf_d;
			rb8_q     <= rb8_d;
			rx_done_q <= rx_done_d;
		end
	end

	// Outputs come straight from flops
	assign data_pin_o      = dout_q;
	assign data_pin_oe_n_o = doe_n_q;
	assign txd_o           = txd_q;
	assign serial_buffer_o = buf_q;
	assign rx_ninth_bit_o  = rb8_q;
	assign tx_done_flag_o  = tx_done_q;
	assign rx_done_flag_o  = rx_done_q;

endmodule // fms_serial_port

`default_nettype wire

// ==== verification/fms_chk.sv ====
/*
 * Assertion checker for the four-mode serial port top, bound below.
 * Assumes it sees only the top's ports, all on ref_clk_i.
 */
`timescale 1ns/1ps
`default_nettype none

module fms_chk (
	input wire logic              ref_clk_i,        // Clock
	input wire logic              reset_i,          // Async reset, high
	input wire fms_pkg::fms_cfg_s cfg_i,            // Control bits
	input wire logic              buf_wr_i,         // Buffer write
	input wire logic              tx_done_clr_i,    // Tx flag clear
	input wire logic              rx_done_clr_i,    // Rx flag clear
	input wire logic              data_pin_o,       // Data drive value
	input wire logic              data_pin_oe_n_o,  // Low while driving
	input wire logic              txd_o,            // Tx line or shift clock
	input wire logic [7:0]        serial_buffer_o,  // Received byte
	input wire logic              tx_done_flag_o,   // Tx done
	input wire logic              rx_done_flag_o    // Rx done
);
	// ********************************
	// Helpers
	// ********************************
	logic m0;    // Synchronous mode selected
	logic fast;  // Mode 0 at the quarter rate
	assign m0 = {cfg_i.mode_select_high, cfg_i.mode_select_low} == fms_pkg::MODE_SYNC;
	assign fast = m0 && cfg_i.mode_qualifier_bit;

	default clocking @(posedge ref_clk_i); endclocking
	default disable iff (reset_i);

	// Shift clock low time and data lead ahead of the fall
	a_fast_low:
		assert property (fast && $fell(txd_o) |-> ##1 !txd_o ##1 txd_o) else $error("fast low");
	a_slow_low:
		assert property (m0 && !fast && $fell(txd_o) |-> ##1 !txd_o[*5] ##1 txd_o)
		else $error("slow low");
	a_slow_lead:
		assert property (m0 && !fast && $fell(txd_o) && !data_pin_oe_n_o
			|-> data_pin_o == $past(data_pin_o, 3)) else $error("slow data lead");
	a_fast_lead:
		assert property (fast && $fell(txd_o) && !data_pin_oe_n_o |-> $stable(data_pin_o))
		else $error("fast data lead");
	// Flags are sticky until cleared
	a_tx_sticky:
		assert property (tx_done_flag_o && !tx_done_clr_i |=> tx_done_flag_o) else $error("tx flag");
	a_rx_sticky:
		assert property (rx_done_flag_o && !rx_done_clr_i |=> rx_done_flag_o) else $error("rx flag");
	// Buffer moves only with a fresh receive flag, so a full buffer is never overwritten
	a_buf_load:
		assert property (!$stable(serial_buffer_o) |-> $rose(rx_done_flag_o)) else $error("buf load");
	// Done flags appear with the line back at rest or on the stop bit
	a_sync_done:
		assert property ($rose(tx_done_flag_o) && m0 |-> txd_o && data_pin_oe_n_o)
		else $error("sync done");
	a_async_done:
		assert property ($rose(tx_done_flag_o) && !m0 |-> txd_o) else $error("async done");
	// A full receive flag halts mode 0 receive clocking; a buffer write still clocks a send
	a_rx_halt:
		assert property (m0 && rx_done_flag_o && txd_o && data_pin_oe_n_o && !buf_wr_i |=> txd_o)
		else $error("rx not halted");
endmodule // fms_chk

bind fms_serial_port fms_chk chk_u (.ref_clk_i, .reset_i, .cfg_i, .buf_wr_i, .tx_done_clr_i,
	.rx_done_clr_i, .data_pin_o, .data_pin_oe_n_o, .txd_o, .serial_buffer_o, .tx_done_flag_o,
	.rx_done_flag_o);

`default_nettype wire

// ==== verification/fms_partner.sv ====
/*
 * Behavioural far-side serial device: async sender and decoder, mode 0 shifter.
 * Assumes the bench resolves the shared data wire from both drivers.
 */
`timescale 1ns/1ps
`default_nettype none

module fms_partner (
	input  wire logic       clk_i,    // Bench clock
	input  wire logic [1:0] mode_i,   // Port mode
	input  wire logic [7:0] bit_i,    // Clocks per bit
	input  wire logic       txd_i,    // Tx line or shift clock
	input  wire logic       line_i,   // Resolved data wire
	output logic            drv_o,    // Drive value
	output logic            en_o,     // Driving the wire
	output logic            got_v_o,  // Unit decoded
	output logic [8:0]      got_o     // Ninth bit and byte
);
	logic [9:0] sh;
	int         n;
	logic       line_q;

	// The port lets go of the wire on the edge of its last rise, so keep the level
	// from half a clock earlier, where the bit is known to stand
	always @(negedge clk_i)
		line_q <= line_i;

	initial
	begin
		drv_o = 1'b1;
		en_o = 1'b0;
		got_v_o = 1'b0;
		got_o = '0;
		n = 0;
	end

	// Hand one decoded unit to the bench for a clock
	task automatic emit(input logic [8:0] v);
		got_o = v;
		got_v_o = 1'b1;
		@(posedge clk_i);
		got_v_o = 1'b0;
	endtask

	// Async frame LSB first; the last bit is left on the wire as idle
	task automatic send(input logic [10:0] f, input int k, input int len);
		en_o = 1'b1;
		for (int i = 0; i < k; i++)
		begin
			drv_o = f[i];
			repeat (len) @(negedge clk_i);
		end
	endtask

	// Mode 0 receive by the port: new bit at each falling shift clock
	task automatic shift_in(input logic [7:0] b);
		en_o = 1'b1;
		for (int i = 0; i < 8; i++)
		begin
			@(negedge txd_i);
			drv_o = b[i];
		end
		@(posedge txd_i);
		en_o = 1'b0;
	endtask

	// Mode 0 transmit by the port: sample at each rising shift clock
	// The rise out of the unknown level at time zero is no shift clock
	always @(posedge txd_i)
		if (mode_i == 2'h0 && en_o === 1'b0 && $time > 0)
		begin
			sh[n] = line_q;
			n++;
			if (n == 8)
			begin
				n = 0;
				emit({1'b0, sh[7:0]});
			end
		end

	// Async transmit by the port: mid-bit samples after the start edge
	always @(negedge txd_i)
		if (mode_i != 2'h0)
		begin
			repeat (bit_i / 2) @(posedge clk_i);
			for (int i = 0; i < 9; i++)
			begin
				repeat (bit_i) @(posedge clk_i);
				sh[i] = txd_i;
			end
			emit(sh[8:0]);
		end
endmodule // fms_partner

`default_nettype wire

// ==== verification/testbench.sv ====
/*
 * Self-checking bench for the four-mode serial port.
 * Assumes the partner model at the pins; the data wire is resolved here.
 */
`timescale 1ns/1ps
`default_nettype none

module testbench;
	logic              clk, rst, ovf, wr, tclr, rclr, dout, oe_n, txd, rnin;
	logic              tflag, rflag, pdrv, pen, gv, line, n9;
	logic              rprev = 1'b0;
	logic [7:0]        wdata, rbuf, b;
	logic [8:0]        got;
	logic [9:0]        e;
	logic [9:0]        txq[$];
	logic [9:0]        rxq[$];
	fms_pkg::fms_cfg_s cfg;
	int                num_errors = 0;
	int                n_compared = 0;
	int                seed = 32'h0047660a;
	int                cyc = 0;
	int                oc = 0;
	int                bc, k, nb;

	initial
	begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end

	fms_serial_port dut_u (.ref_clk_i(clk), .reset_i(rst), .cfg_i(cfg), .timer_ovf_i(ovf),
		.buf_wr_i(wr), .buf_wdata_i(wdata), .tx_done_clr_i(tclr), .rx_done_clr_i(rclr),
		.data_pin_i(line), .data_pin_o(dout), .data_pin_oe_n_o(oe_n), .txd_o(txd),
		.serial_buffer_o(rbuf), .rx_ninth_bit_o(rnin), .tx_done_flag_o(tflag),
		.rx_done_flag_o(rflag));

	fms_partner partner_u (.clk_i(clk), .mode_i({cfg.mode_select_high, cfg.mode_select_low}),
		.bit_i(bc[7:0]), .txd_i(txd), .line_i(line), .drv_o(pdrv), .en_o(pen), .got_v_o(gv),
		.got_o(got));

	// Released wire shows the inverse of the partner's last drive value, never a kind value
	assign line = !oe_n ? dout : pen ? pdrv : ~pdrv;

	// Timer overflow every third clock
	always @(negedge clk)
	begin
		oc <= (oc == 2) ? 0 : oc + 1;
		ovf <= (oc == 2);
	end

	task automatic close_out();
		if (num_errors == 0 && n_compared > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	task automatic chk(input logic [9:0] seen, input logic [9:0] exp, input string m);
		n_compared++;
		if (seen !== exp)
		begin
			num_errors++;
			$display("BAD %0t %s: %h expected %h", $time, m, seen, exp);
		end
	endtask

	function automatic logic [9:0] pop(ref logic [9:0] q[$]);
		return q.size() ? q.pop_front() : 10'h3ff;
	endfunction

	// Hang guard, well above the expected run
	always @(posedge clk)
	begin
		cyc++;
		if (cyc == 60000)
		begin
			num_errors++;
			close_out();
		end
	end

	// Results are matched to the oldest note as they appear
	always @(negedge clk)
	begin
		rprev <= rflag;
		if (gv === 1'b1)
			chk({1'b0, got}, pop(txq), "tx unit");
		if (rflag === 1'b1 && rprev === 1'b0)
		begin
			if (rxq.size() == 0)
				chk(10'h0, 10'h1, "extra rx");
			e = pop(rxq);
			chk({e[9], e[9] ? rnin : e[8], rbuf}, e, "rx unit");
		end
	end

	task automatic write(input logic [7:0] d);
		wr = 1'b1;
		wdata = d;
		@(negedge clk);
		wr = 1'b0;
	endtask

	// Bounded wait for a done flag, optionally clearing it
	task automatic done(input bit rx, input bit c, output int kk);
		kk = 0;
		while ((rx ? rflag : tflag) !== 1'b1 && kk < 4000)
		begin
			@(negedge clk);
			kk++;
		end
		chk({9'h0, kk < 4000}, 10'h1, "flag late");
		rclr = rx & c;
		tclr = !rx & c;
		@(negedge clk);
		rclr = 1'b0;
		tclr = 1'b0;
	endtask

	initial
	begin
		cfg = '0;
		{rst, wr, wdata, tclr, rclr, bc} = {2'b10, 8'h00, 2'b00, 32'd32};
		repeat (6) @(negedge clk);
		rst = 1'b0;
		// Mode 0 send at the quarter and twelfth rates
		for (int q = 1; q >= 0; q--)
		begin
			cfg.mode_qualifier_bit = q[0];
			b = $random(seed);
			txq.push_back({2'b00, b});
			write(b);
			done(0, 1, k);
			chk((k + 1) / (q ? 4 : 12), 10'h8, "shift rate");
		end
		// Mode 0 receive, then halt while the flag stays set
		b = $random(seed);
		rxq.push_back({2'b00, b});
		fork
			partner_u.shift_in(b);
		join_none
		cfg.rx_enable = 1'b1;
		done(1, 0, k);
		repeat (40) @(negedge clk);
		chk({9'h0, txd}, 10'h1, "rx halted");
		cfg.rx_enable = 1'b0;
		done(1, 1, k);
		partner_u.send(11'h7ff, 1, 1);
		// Every async mode and rate: one send, one receive
		for (int m = 1; m < 4; m++)
			for (int d = 0; d < 2; d++)
			begin
				cfg.mode_select_high = m[1];
				cfg.mode_select_low = m[0];
				cfg.baud_double_bit = d[0];
				cfg.tx_ninth_bit = $random(seed);
				cfg.rx_enable = 1'b1;
				bc = (m == 2) ? (d ? 32 : 64) : (d ? 48 : 96);
				nb = (m == 1) ? 10 : 11;
				repeat (bc * 2) @(negedge clk);
				b = $random(seed);
				txq.push_back({1'b0, (m == 1) | cfg.tx_ninth_bit, b});
				write(b);
				done(0, 1, k);
				chk(k >= (nb - 1) * bc - 2 && k <= nb * bc + 2, 10'h1, "tx time");
				repeat (bc * 2) @(negedge clk);
				b = $random(seed);
				n9 = $random(seed) | (m == 1);
				rxq.push_back({1'b1, n9, b});
				partner_u.send({1'b1, n9, b, 1'b0}, nb, bc);
				done(1, 1, k);
			end
		// Qualifier set: ninth bit 0 is dropped, a full buffer is kept
		cfg.mode_select_low = 1'b0;
		cfg.mode_qualifier_bit = 1'b1;
		bc = 32;
		b = $random(seed);
		partner_u.send({2'b10, b, 1'b0}, 11, bc);
		repeat (bc) @(negedge clk);
		chk({9'h0, rflag}, 10'h0, "unqualified load");
		rxq.push_back({2'b11, b});
		partner_u.send({2'b11, b, 1'b0}, 11, bc);
		done(1, 0, k);
		partner_u.send({2'b11, ~b, 1'b0}, 11, bc);
		repeat (bc) @(negedge clk);
		chk({2'b00, rbuf}, {2'b00, b}, "load while full");
		done(1, 1, k);
		// Short low pulse is rejected, the following frame still lands
		partner_u.send(11'h002, 2, 8);
		// Idle long enough for the abort at mid start bit before the next edge
		repeat (bc) @(negedge clk);
		rxq.push_back({2'b11, ~b});
		partner_u.send({2'b11, ~b, 1'b0}, 11, bc);
		done(1, 1, k);
		close_out();
	end
endmodule // testbench

`default_nettype wire
